/* pkg/pm_pkg.sv */
// constants and types shared by the processor end and the power manager end
// Notes on behaviour
// - core zone clocked only while its enable high
// - timer zone gated by its own enable and by the parked clock
// - manager holds scan zone enable at one
// - stopped processor clock parks high, not low
// - processor clock feeds core and timer, not scan
// - timer irq or watchdog request wakes core
// - outside chip reset request wakes core
// - enabled external or critical interrupt wakes core
// - debugger halt wakes core
// - stopped flag high while core clocks disabled
// - timers step on each clock with tick
// - enable outputs mirror machine state bits
// - timer irq output high while timer pending
// - watchdog request high while reset pending
// - sleep request raised when core asks sleep
// - sleep request only after wait bit, drained
// - enables and timer irq drop before sleep request falls
// - watchdog request ORs core, chip, system modes
package pm_pkg;
    // ************************************************************
    // timer and register layout
    // ************************************************************
    localparam int unsigned TB_W = 32;
    localparam logic [TB_W-1:0] TB_RST = 32'h0000_0000;
    localparam logic [TB_W-1:0] PIT_RST = 32'h0000_0000;
    localparam logic [TB_W-1:0] PIT_ZERO = 32'h0000_0000;
    localparam logic [TB_W-1:0] PIT_ONE = 32'h0000_0001;
    localparam logic [TB_W-1:0] TB_ONE = 32'h0000_0001;
    localparam int unsigned WD_W = 3;     // core, chip, system reset modes
    localparam logic [WD_W-1:0] WD_NONE = 3'h0;
    localparam int unsigned FIT_BIT = 4;  // time base bit for the fixed timer
    localparam int unsigned WDT_BIT = 8;  // time base bit for the watchdog
    localparam int unsigned DRAIN_W = 3;
    localparam logic [DRAIN_W-1:0] DRAIN_CYC = 3'h3; // cycles to let accesses finish
    localparam logic [DRAIN_W-1:0] DRAIN_ZERO = 3'h0;
    localparam logic [DRAIN_W-1:0] DRAIN_ONE = 3'h1;
    // ************************************************************
    // manager register map (AHB-Lite, word offsets)
    // ************************************************************
    localparam logic [7:0] A_CTRL = 8'h00;   // bit0 sleep enable, bit1 gate mode
    localparam logic [7:0] A_STAT = 8'h04;   // sticky events, write one clears
    localparam logic [7:0] A_MASK = 8'h08;
    localparam logic [7:0] A_LIVE = 8'h0c;   // live link state
    localparam int unsigned EV_W = 3;        // bit0 slept, bit1 woke, bit2 wdog
    localparam logic [EV_W-1:0] EV_NONE = 3'h0;
    localparam logic [1:0] CTRL_RST = 2'h1;
    typedef enum logic [1:0] {PM_RUN, PM_SLEEP, PM_WAKE} pm_state_t;
endpackage

/* pkg/pm_link_if.sv */
// link between the processor end and the power manager end
`timescale 1ns/10ps
`default_nettype none
interface pm_link_if;
    logic proc_clk_in;
    logic core_zone_clk_en;
    logic timer_zone_clk_en;
    logic scan_zone_clk_en;
    logic core_clk_stopped_flag;
    logic timer_tick_in;
    logic ext_irq_enable_out;
    logic crit_irq_enable_out;
    logic timer_irq_req;
    logic wdog_reset_req;
    logic core_sleep_req;
    modport proc (input proc_clk_in, core_zone_clk_en, timer_zone_clk_en, scan_zone_clk_en,
        core_clk_stopped_flag, timer_tick_in,
        output ext_irq_enable_out, crit_irq_enable_out, timer_irq_req, wdog_reset_req,
        core_sleep_req);
    modport mgr (output proc_clk_in, core_zone_clk_en, timer_zone_clk_en, scan_zone_clk_en,
        core_clk_stopped_flag, timer_tick_in,
        input ext_irq_enable_out, crit_irq_enable_out, timer_irq_req, wdog_reset_req,
        core_sleep_req);
endinterface
`default_nettype wire

/* core/proc_pm_end.sv */
// processor end: zone gating, timers, sleep handshake
`timescale 1ns/10ps
`default_nettype none
module proc_pm_end (
    // link to the power manager
    pm_link_if.proc link,
    // reset
    input wire logic hresetn,
    // machine state bits written by the core
    input wire logic ext_int_enable_bit,
    input wire logic crit_int_enable_bit,
    input wire logic wait_state_enable_bit,
    input wire logic core_busy,
    // timer setup from the core
    input wire logic pit_load,
    input wire logic [pm_pkg::TB_W-1:0] pit_value,
    input wire logic [pm_pkg::WD_W-1:0] wdog_mode,
    input wire logic timer_irq_ack,
    input wire logic wdog_ack,
    // status back to the core
    output logic core_run,
    output logic [pm_pkg::TB_W-1:0] time_base,
    output logic stopped_seen
);
    import pm_pkg::*;
    logic clk;
    logic core_en, timer_en, tick;
    logic [TB_W-1:0] tb_r, tb_nxt, pit_r;
    logic pit_irq_r, fit_irq_r, wdt_irq_r;
    logic [WD_W-1:0] wd_pend_r;
    logic [DRAIN_W-1:0] drain_r;
    logic sleep_r, ee_r, ce_r, tirq_r, wd_r, stop_r;
    logic tb_step, fit_rise, wdt_rise, pend_irq, wake_ev;

    // ************************************************************
    // zone enables and tick
    // ************************************************************
    // all non-scan logic runs on the processor clock; scan zone is not here
    assign clk = link.proc_clk_in;
    assign core_en = link.core_zone_clk_en;
    assign timer_en = link.timer_zone_clk_en;
    assign tick = link.timer_tick_in;
    assign tb_step = timer_en && tick;
    assign tb_nxt = tb_r + TB_ONE;
    assign fit_rise = tb_step && !tb_r[FIT_BIT] && tb_nxt[FIT_BIT];
    assign wdt_rise = tb_step && !tb_r[WDT_BIT] && tb_nxt[WDT_BIT];
    assign pend_irq = pit_irq_r || fit_irq_r || wdt_irq_r;

    // ************************************************************
    // timer zone: runs while the core zone enable is low so it can wake it
    // ************************************************************
    always_ff @(posedge clk or negedge hresetn) begin
        if (!hresetn) begin
            tb_r <= TB_RST;
        end else if (tb_step) begin
            tb_r <= tb_nxt;
        end
    end

    // pit counts down one per tick; core writes only while its zone runs
    always_ff @(posedge clk or negedge hresetn) begin
        if (!hresetn) begin
            pit_r <= PIT_RST;
        end else if (core_en && pit_load) begin
            pit_r <= pit_value;
        end else if (tb_step && pit_r != PIT_ZERO) begin
            pit_r <= pit_r - PIT_ONE;
        end
    end

    // timer interrupt sources; a new event beats a same-cycle ack
    always_ff @(posedge clk or negedge hresetn) begin
        if (!hresetn) begin
            pit_irq_r <= 1'b0;
            fit_irq_r <= 1'b0;
            wdt_irq_r <= 1'b0;
            wd_pend_r <= WD_NONE;
        end else begin
            pit_irq_r <= (tb_step && pit_r == PIT_ONE) || (pit_irq_r && !(core_en && timer_irq_ack));
            fit_irq_r <= fit_rise || (fit_irq_r && !(core_en && timer_irq_ack));
            wdt_irq_r <= wdt_rise || (wdt_irq_r && !(core_en && timer_irq_ack));
            wd_pend_r <= (wdt_irq_r && wdt_rise) ? wdog_mode  // second expiry resets
                       : ((core_en && wdog_ack) ? WD_NONE : wd_pend_r);
        end
    end

    // ************************************************************
    // core zone: sleep handshake, frozen while its enable is low
    // ************************************************************
    // drain counter models prior instructions and accesses finishing
    always_ff @(posedge clk or negedge hresetn) begin
        if (!hresetn) begin
            drain_r <= DRAIN_ZERO;
            sleep_r <= 1'b0;
        end else if (core_en) begin
            if (!wait_state_enable_bit || wake_ev) begin
                drain_r <= DRAIN_ZERO;
            end else if (core_busy) begin
                drain_r <= DRAIN_ZERO;
            end else if (drain_r != DRAIN_CYC) begin
                drain_r <= drain_r + DRAIN_ONE;
            end
            // raise when drained drop one cycle after the enables
            if (!sleep_r) begin
                sleep_r <= wait_state_enable_bit && !core_busy && drain_r == DRAIN_CYC;
            end else if (!ee_r && !ce_r && !tirq_r && !wait_state_enable_bit) begin
                sleep_r <= 1'b0;
            end
        end
    end

    // wake is seen as the core dropping its wait bit while asleep
    assign wake_ev = sleep_r && !wait_state_enable_bit;

    // ************************************************************
    // link outputs, all registered
    // ************************************************************
    always_ff @(posedge clk or negedge hresetn) begin
        if (!hresetn) begin
            ee_r <= 1'b0;
            ce_r <= 1'b0;
            tirq_r <= 1'b0;
            wd_r <= 1'b0;
            stop_r <= 1'b0;
        end else begin
            // on wake the three drop first, sleep request follows
            ee_r <= ext_int_enable_bit && !wake_ev;
            ce_r <= crit_int_enable_bit && !wake_ev;
            tirq_r <= pend_irq && !wake_ev;
            wd_r <= |wd_pend_r;
            stop_r <= link.core_clk_stopped_flag;
        end
    end

    assign link.ext_irq_enable_out = ee_r;
    assign link.crit_irq_enable_out = ce_r;
    assign link.timer_irq_req = tirq_r;
    assign link.wdog_reset_req = wd_r;
    assign link.core_sleep_req = sleep_r;
    assign core_run = core_en;
    assign time_base = tb_r;
    assign stopped_seen = stop_r;
endmodule
`default_nettype wire

/* core/pm_mgr_end.sv */
// power manager end: AHB-Lite registers, wake logic, clock gating
`timescale 1ns/10ps
`default_nettype none
module pm_mgr_end (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // wake sources
    input wire logic ext_irq_in,
    input wire logic crit_irq_in,
    input wire logic chip_reset_req,
    input wire logic debugger_halt_in,
    output logic irq,
    // link to the processor
    pm_link_if.mgr link
);
    import pm_pkg::*;
    pm_state_t st_r, st_nxt;
    logic [1:0] ctrl_r;
    logic [EV_W-1:0] stat_r, mask_r, ev;
    logic ee_l, ce_l, ti_l, wd_l, sl_l;
    logic core_en_r, clk_hold_r, stop_r, irq_r;
    logic ap_r, aw_r;
    logic [7:0] aa_r;
    logic [31:0] rd_r;
    logic wake, wr_stat, wr_mask, wr_ctrl, take;

    // ************************************************************
    // bus slave: zero wait states, always OKAY
    // ************************************************************
    assign take = hsel && hready && htrans[1];
    assign wr_ctrl = ap_r && aw_r && aa_r == A_CTRL;
    assign wr_stat = ap_r && aw_r && aa_r == A_STAT;
    assign wr_mask = ap_r && aw_r && aa_r == A_MASK;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_r <= 1'b0;
            aw_r <= 1'b0;
            aa_r <= 8'h00;
        end else begin
            ap_r <= take;
            aw_r <= hwrite;
            aa_r <= haddr[7:0];
        end
    end
    // read data registered at the address phase, unmapped reads zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_r <= 32'h0000_0000;
        end else if (take && !hwrite) begin
            case (haddr[7:0])
                A_CTRL: rd_r <= {30'h0, ctrl_r};
                A_STAT: rd_r <= {29'h0, stat_r};
                A_MASK: rd_r <= {29'h0, mask_r};
                A_LIVE: rd_r <= {26'h0, st_r == PM_SLEEP, sl_l, wd_l, ti_l, ce_l, ee_l};
                default: rd_r <= 32'h0000_0000;
            endcase
        end
    end
    assign hrdata = rd_r;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // ************************************************************
    // latch processor outputs before use, since they fall early
    // ************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ee_l <= 1'b0;
            ce_l <= 1'b0;
            ti_l <= 1'b0;
            wd_l <= 1'b0;
            sl_l <= 1'b0;
        end else begin
            ee_l <= link.ext_irq_enable_out;
            ce_l <= link.crit_irq_enable_out;
            ti_l <= link.timer_irq_req;
            wd_l <= link.wdog_reset_req;
            sl_l <= link.core_sleep_req;
        end
    end

    // wake sources
    assign wake = ti_l || wd_l
                || chip_reset_req
                || (ext_irq_in && ee_l)
                || (crit_irq_in && ce_l)
                || debugger_halt_in;

    // ************************************************************
    // sleep state machine
    // ************************************************************
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            PM_RUN: if (sl_l && ctrl_r[0] && !wake) st_nxt = PM_SLEEP;
            PM_SLEEP: if (wake) st_nxt = PM_WAKE;
            PM_WAKE: if (!sl_l) st_nxt = PM_RUN; // hold clocks on until request drops
            default: st_nxt = PM_RUN;
        endcase
    end
    assign ev = {wd_l, st_r == PM_SLEEP && st_nxt == PM_WAKE,
                 st_r == PM_RUN && st_nxt == PM_SLEEP};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r <= PM_RUN;
            core_en_r <= 1'b1;
            clk_hold_r <= 1'b0;
            stop_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            // gate mode 0 uses the zone enable, 1 parks the clock
            core_en_r <= !(st_nxt == PM_SLEEP && !ctrl_r[1]);
            clk_hold_r <= st_nxt == PM_SLEEP && ctrl_r[1];
            stop_r <= st_nxt == PM_SLEEP;
        end
    end

    // ************************************************************
    // control, sticky status and mask; a set beats a clear
    // ************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r <= CTRL_RST;
            stat_r <= EV_NONE;
            mask_r <= EV_NONE;
            irq_r <= 1'b0;
        end else begin
            if (wr_ctrl) ctrl_r <= hwdata[1:0];
            if (wr_mask) mask_r <= hwdata[EV_W-1:0];
            stat_r <= ev | (stat_r & ~(wr_stat ? hwdata[EV_W-1:0] : EV_NONE));
            irq_r <= |(stat_r & mask_r);
        end
    end
    assign irq = irq_r;

    // ************************************************************
    // link drive: clock parked high when held
    // ************************************************************
    assign link.proc_clk_in = hclk || clk_hold_r;
    assign link.core_zone_clk_en = core_en_r;
    assign link.timer_zone_clk_en = 1'b1;
    assign link.scan_zone_clk_en = 1'b1;
    assign link.core_clk_stopped_flag = stop_r;
    assign link.timer_tick_in = 1'b1;
endmodule
`default_nettype wire

/* test/pm_link_chk.sv */
// concurrent checks on the link between the processor end and the manager end
`timescale 1ns/10ps
`default_nettype none
module pm_link_chk (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // link signals
    input wire logic proc_clk_in,
    input wire logic core_zone_clk_en,
    input wire logic timer_zone_clk_en,
    input wire logic scan_zone_clk_en,
    input wire logic core_clk_stopped_flag,
    input wire logic timer_tick_in,
    input wire logic ext_irq_enable_out,
    input wire logic crit_irq_enable_out,
    input wire logic timer_irq_req,
    input wire logic wdog_reset_req,
    input wire logic core_sleep_req
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ************************************************************
    // wake must land within a few manager cycles: latch, fsm, flag
    // ************************************************************
    sequence s_awake;
        ##[1:5] !core_clk_stopped_flag;
    endsequence
    a_scan_tied: assert property (scan_zone_clk_en)
        else $error("scan zone enable dropped");
    a_timer_tied: assert property (timer_zone_clk_en && timer_tick_in)
        else $error("timer zone enable or tick dropped");
    a_stop_gated: assert property (core_clk_stopped_flag |-> !core_zone_clk_en || proc_clk_in)
        else $error("stopped flag while core still clocked");
    a_stop_on_req: assert property ($rose(core_clk_stopped_flag) |-> core_sleep_req)
        else $error("core stopped without a sleep request");
    // enables and timer request must already be low one cycle before the request falls
    a_drop_order: assert property ($fell(core_sleep_req) |->
        !$past(ext_irq_enable_out) && !$past(crit_irq_enable_out) && !$past(timer_irq_req))
        else $error("sleep request fell before enables");
    a_timer_wake: assert property (timer_irq_req && core_clk_stopped_flag |-> s_awake)
        else $error("timer request did not wake core");
    a_wdog_wake: assert property (wdog_reset_req && core_clk_stopped_flag |-> s_awake)
        else $error("watchdog request did not wake core");
    a_wdog_cause: assert property ($rose(wdog_reset_req) |-> $past(timer_irq_req))
        else $error("watchdog request without pending expiry");
endmodule
`default_nettype wire

/* test/tb.sv */
// bench joining the processor end and the manager end over the link
`timescale 1ns/10ps
`default_nettype none
module tb;
    import pm_pkg::*;
    // ************************************************************
    // stimulus, observed outputs and reference model state
    // ************************************************************
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic ext_irq_in = 1'b0, crit_irq_in = 1'b0, chip_reset_req = 1'b0, debugger_halt_in = 1'b0;
    logic ext_en_b = 1'b0, crit_en_b = 1'b0, wait_b = 1'b0, busy = 1'b0, tack = 1'b0, wack = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, time_base, rd, t0;
    logic [1:0] htrans = 2'h0, en;
    logic [2:0] hsize = 3'h2, wdog_mode = 3'h0;
    logic hreadyout, hresp, irq, core_run, stopped_seen;
    int err_count = 0, compares = 0, seed = 32'hc7b9, stat_m = 0, mask_m = 0, n;
    pm_link_if link();
    wire stop_f = link.core_clk_stopped_flag;
    always #50 hclk = ~hclk;
    // ************************************************************
    // the two ends and the checker
    // ************************************************************
    proc_pm_end proc_pm_end_i (.link(link), .hresetn(hresetn), .ext_int_enable_bit(ext_en_b),
        .crit_int_enable_bit(crit_en_b), .wait_state_enable_bit(wait_b), .core_busy(busy),
        .pit_load(1'b0), .pit_value(32'h0), .wdog_mode(wdog_mode), .timer_irq_ack(tack),
        .wdog_ack(wack), .core_run(core_run), .time_base(time_base), .stopped_seen(stopped_seen));
    pm_mgr_end pm_mgr_end_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ext_irq_in(ext_irq_in),
        .crit_irq_in(crit_irq_in), .chip_reset_req(chip_reset_req),
        .debugger_halt_in(debugger_halt_in), .irq(irq), .link(link));
    pm_link_chk pm_link_chk_i (.hclk(hclk), .hresetn(hresetn), .proc_clk_in(link.proc_clk_in),
        .core_zone_clk_en(link.core_zone_clk_en), .timer_zone_clk_en(link.timer_zone_clk_en),
        .scan_zone_clk_en(link.scan_zone_clk_en), .core_clk_stopped_flag(stop_f),
        .timer_tick_in(link.timer_tick_in), .ext_irq_enable_out(link.ext_irq_enable_out),
        .crit_irq_enable_out(link.crit_irq_enable_out), .timer_irq_req(link.timer_irq_req),
        .wdog_reset_req(link.wdog_reset_req), .core_sleep_req(link.core_sleep_req));
    // ************************************************************
    // helpers
    // ************************************************************
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
            err_count++;
        end
    endtask
    // one single AHB-Lite word transfer; the register model follows writes
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        if (w && a == A_STAT) stat_m &= ~d;
        if (w && a == A_MASK) mask_m = d;
    endtask
    task automatic irq_chk();
        repeat (2) @(posedge hclk);
        chk("irq", ((stat_m & mask_m) != 0), irq);
    endtask
    task automatic wait_stop(input logic v, input int lim);
        n = 0;
        while (stop_f !== v && n < lim) begin
            @(posedge hclk);
            n++;
        end
    endtask
    // sleep entry aligned just after a fixed-timer event and far from a watchdog step,
    // so no timer event wakes us before the wake source under test
    task automatic sleep_in();
        while (time_base[8:0] !== 9'h012) @(posedge hclk);
        tack <= 1'b1;
        busy <= 1'b1;
        wait_b <= 1'b1;
        @(posedge hclk);
        tack <= 1'b0;
        repeat (4) @(posedge hclk);
        chk("req_busy", 0, link.core_sleep_req);
        busy <= 1'b0;
        wait_stop(1'b1, 12);
        chk("stopped", 1, stop_f);
    endtask
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // ************************************************************
    // watchdog: the whole sequence needs a few thousand cycles at most
    // ************************************************************
    initial begin
        #2000000;
        err_count++;
        tally_and_finish();
    end
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        bus(0, A_CTRL, 0);
        chk("ctrl", 32'h1, rd);
        bus(0, A_STAT, 0);
        chk("stat", 32'h0, rd);
        bus(0, 8'h10, 0);
        chk("unmapped", 32'h0, rd);
        chk("hresp", 0, hresp);
        chk("scan_en", 1, link.scan_zone_clk_en);
        chk("tick", 1, link.timer_tick_in);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            en = 2'($random(seed));
            ext_en_b <= en[1];
            crit_en_b <= en[0];
            repeat (3) @(posedge hclk);
            chk("ext_en_out", en[1], link.ext_irq_enable_out);
            chk("crit_en_out", en[0], link.crit_irq_enable_out);
            bus(0, A_LIVE, 0);
            chk("live_en", {en[0], en[1]}, rd[1:0]);
        end
        @(negedge hclk);
        t0 = time_base;
        repeat (20) @(negedge hclk);
        chk("time_base", t0 + 32'h14, time_base);
        $display("test mirror and time base done");
        bus(1, A_MASK, 32'h7);
        // wake by ext, crit, chip reset, debugger; the last one in parked-clock mode
        for (int s = 0; s < 4; s++) begin
            en = (s == 0) ? 2'h2 : (s == 1) ? 2'h1 : 2'h0;
            ext_en_b <= en[1];
            crit_en_b <= en[0];
            bus(1, A_CTRL, (s == 3) ? 32'h3 : 32'h1);
            sleep_in();
            chk("core_en", (s == 3), link.core_zone_clk_en);
            chk("core_run", (s == 3), core_run);
            ext_irq_in <= !en[1];
            crit_irq_in <= !en[0];
            @(negedge hclk);
            t0 = time_base;
            repeat (3) @(negedge hclk);
            chk("timer_zone", (s == 3) ? t0 : t0 + 32'h3, time_base);
            chk("park_high", 1, (s == 3) ? link.proc_clk_in : 1'b1);
            chk("masked_irq", 1, stop_f);
            chk("stopped_seen", (s != 3), stopped_seen);
            @(posedge hclk);
            ext_irq_in <= 1'b1;
            crit_irq_in <= 1'b1;
            chip_reset_req <= (s == 2);
            debugger_halt_in <= (s == 3);
            wait_stop(1'b0, 8);
            chk("woken", 0, stop_f);
            {wait_b, ext_irq_in, crit_irq_in, chip_reset_req, debugger_halt_in} <= 5'h0;
            stat_m |= 3;
            irq_chk();
            bus(0, A_STAT, 0);
            chk("stat_sleep", stat_m, rd);
            bus(1, A_STAT, 32'h3);
            irq_chk();
        end
        $display("test wake sources done");
        bus(1, A_CTRL, 32'h1);
        sleep_in();
        wait_stop(1'b0, 40);
        chk("timer_wake", 0, stop_f);
        wait_b <= 1'b0;
        stat_m |= 3;
        bus(1, A_STAT, 32'h3);
        $display("test timer wake done");
        wdog_mode <= 3'(1 + ({$random(seed)} % 7));
        bus(1, A_MASK, 32'h3);
        n = 0;
        while (link.wdog_reset_req !== 1'b1 && n < 1100) begin
            @(posedge hclk);
            n++;
        end
        chk("wdog_req", 1, link.wdog_reset_req);
        stat_m |= 4;
        bus(0, A_STAT, 0);
        chk("stat_wdog", stat_m, rd);
        irq_chk();
        bus(1, A_MASK, 32'h7);
        irq_chk();
        wack <= 1'b1;
        tack <= 1'b1;
        @(posedge hclk);
        wack <= 1'b0;
        tack <= 1'b0;
        repeat (3) @(posedge hclk);
        chk("wdog_clear", 0, link.wdog_reset_req);
        bus(1, A_STAT, 32'h4);
        irq_chk();
        $display("test watchdog done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
